// ### src/cwt_pkg.sv
// Shared constants for the color sensor wait, threshold and status block.
// Assumes a single 250 MHz core clock and an upstream register decoder.
package cwt_pkg;

	// Register offsets on the internal 5-bit register address
	localparam logic [4:0] ADDR_WAIT_INTERVAL = 5'h03;
	localparam logic [4:0] ADDR_LOW_THRESH_LO = 5'h04;
	localparam logic [4:0] ADDR_LOW_THRESH_HI = 5'h05;
	localparam logic [4:0] ADDR_HIGH_THRESH_LO = 5'h06;
	localparam logic [4:0] ADDR_HIGH_THRESH_HI = 5'h07;
	localparam logic [4:0] ADDR_INTERRUPT_FILTER = 5'h0c;
	localparam logic [4:0] ADDR_WAIT_CONFIG = 5'h0d;
	localparam logic [4:0] ADDR_GAIN_CONTROL = 5'h0f;
	localparam logic [4:0] ADDR_PART_IDENTITY = 5'h12;
	localparam logic [4:0] ADDR_SENSOR_STATUS = 5'h13;

	// Field positions
	localparam int LONG_WAIT_BIT = 1;
	localparam int STATUS_INT_BIT = 4;
	localparam int STATUS_VALID_BIT = 0;
	localparam int FILTER_W = 4;
	localparam int GAIN_W = 2;

	// Reset values
	localparam logic [7:0] WAIT_INTERVAL_RST = 8'hff;
	localparam logic [7:0] THRESH_BYTE_RST = 8'h00;
	localparam logic [7:0] HIGH_THRESH_BYTE_RST = 8'hff;
	localparam logic [3:0] FILTER_RST = 4'h0;
	localparam logic [1:0] GAIN_RST = 2'h0;
	// Arbitrary neutral part code, not any real product's value
	localparam logic [7:0] PART_IDENTITY_DEFAULT = 8'h5a;

	// Persistence code mapping
	localparam logic [3:0] FILTER_EVERY = 4'h0;
	localparam logic [3:0] FILTER_LAST_DIRECT = 4'h3;
	localparam logic [5:0] FILTER_STEP = 6'h05;
	localparam logic [5:0] OOR_COUNT_MAX = 6'h3f;

	// Wait timing
	localparam int CLK_MHZ = 250;
	localparam int WAIT_STEP_US = 2400;
	localparam int WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
	localparam int LONG_WAIT_FACTOR = 12;
	localparam logic [8:0] WAIT_STEPS_FULL = 9'h100;

	// Wait timer states
	typedef enum logic [1:0] {
		WT_IDLE = 2'b00,
		WT_RUN = 2'b01,
		WT_DONE = 2'b10
	} cwt_wait_state_t;

endpackage

// ### src/cwt_threshold_status.sv
// Wait, threshold, persistence, gain, identity and status registers
// of a color sensor measurement sequencer.
// Assumes an upstream bus decoder on the same clock that presents byte
// register accesses and the interrupt clear command as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module cwt_threshold_status #(
	parameter int WAIT_STEP_CYCLES = cwt_pkg::WAIT_STEP_CYCLES,
	parameter logic [7:0] PART_IDENTITY = cwt_pkg::PART_IDENTITY_DEFAULT,
	parameter int RESULT_W = 16
) (
	input wire logic clk, // Core clock, 250 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic [4:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Write byte
	input wire logic regWrEn, // Write strobe
	input wire logic regRdEn, // Read strobe
	output logic [7:0] regRdData, // Read byte, one cycle after strobe
	output logic regRdValid, // Read byte valid pulse
	input wire logic intClearCmd, // Interrupt clear command pulse
	input wire logic interruptEnableBit, // Interrupt enable level
	input wire logic waitEnable, // Wait enable level
	input wire logic measureEnable, // Measurement enable level
	input wire logic resultStrobe, // End of integration pulse
	input wire logic [RESULT_W-1:0] clearResult, // Clear channel result
	input wire logic waitStart, // Start wait interval pulse
	output logic waitBusy, // Wait interval running
	output logic waitDone, // Wait interval finished pulse
	output logic [1:0] analogGainSelect, // Gain code to analog
	output logic [3:0] gainMultiplier, // Gain as 1 4 16 or 60 code
	output logic intPinOut, // Interrupt pin drive level
	output logic intPinOe // Interrupt pin pulled low when high
);

	logic [7:0] waitIntervalSetting_r;
	logic [7:0] lowThreshLo_r;
	logic [7:0] lowThreshHi_r;
	logic [7:0] highThreshLo_r;
	logic [7:0] highThreshHi_r;
	logic [3:0] interruptFilterCount_r;
	logic longWaitSelect_r;
	logic [1:0] analogGainSelect_r;
	logic [3:0] gainMultiplier_r;
	logic [5:0] oorCount_r;
	logic [5:0] oorCount_nxt;
	logic thresholdIntFlag_r;
	logic resultValidFlag_r;
	logic [7:0] regRdData_r;
	logic regRdValid_r;
	logic intPinOe_r;
	logic timerBusy;
	logic timerDone;
	logic waitBusy_r;
	logic waitDone_r;
	logic [15:0] lowThresh;
	logic [15:0] highThresh;
	logic outOfRange;
	logic intFire;
	logic resultTaken;
	logic intSet;
	logic clearTaken;
	logic [7:0] statusByte;

	// Consecutive out-of-range results needed for a filter code
	function automatic logic [5:0] filterNeed(input logic [3:0] code);
		logic [5:0] need;
		need = 6'h00;
		if (code <= cwt_pkg::FILTER_LAST_DIRECT) begin
			need = {2'b00, code};
		end else begin
			need = 6'({2'b00, code} - {2'b00, cwt_pkg::FILTER_LAST_DIRECT}) *
				cwt_pkg::FILTER_STEP;
		end
		return need;
	endfunction

	// Write strobe decoded for one address
	function automatic logic wrHit(input logic en, input logic [4:0] addr,
		input logic [4:0] target);
		return en && (addr == target);
	endfunction

	// Register writes, one process per register, one per threshold byte pair

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitIntervalSetting_r <= cwt_pkg::WAIT_INTERVAL_RST;
		end else if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_WAIT_INTERVAL)) begin
			waitIntervalSetting_r <= regWrData;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowThreshLo_r <= cwt_pkg::THRESH_BYTE_RST;
			lowThreshHi_r <= cwt_pkg::THRESH_BYTE_RST;
		end else begin
			if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_LOW_THRESH_LO)) begin
				lowThreshLo_r <= regWrData;
			end
			if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_LOW_THRESH_HI)) begin
				lowThreshHi_r <= regWrData;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			highThreshLo_r <= cwt_pkg::HIGH_THRESH_BYTE_RST;
			highThreshHi_r <= cwt_pkg::HIGH_THRESH_BYTE_RST;
		end else begin
			if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_HIGH_THRESH_LO)) begin
				highThreshLo_r <= regWrData;
			end
			if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_HIGH_THRESH_HI)) begin
				highThreshHi_r <= regWrData;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			interruptFilterCount_r <= cwt_pkg::FILTER_RST;
		end else if (wrHit(regWrEn, regAddr,
			cwt_pkg::ADDR_INTERRUPT_FILTER)) begin
			// Reserved upper nibble is not stored
			interruptFilterCount_r <= regWrData[cwt_pkg::FILTER_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			longWaitSelect_r <= 1'b0;
		end else if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_WAIT_CONFIG)) begin
			longWaitSelect_r <= regWrData[cwt_pkg::LONG_WAIT_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			analogGainSelect_r <= cwt_pkg::GAIN_RST;
		end else if (wrHit(regWrEn, regAddr, cwt_pkg::ADDR_GAIN_CONTROL)) begin
			analogGainSelect_r <= regWrData[cwt_pkg::GAIN_W-1:0];
		end
	end

	// Gain multiplier follows the code one cycle later
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gainMultiplier_r <= 4'h0;
		end else begin
			unique case (analogGainSelect_r)
				2'h0: gainMultiplier_r <= 4'h0;
				2'h1: gainMultiplier_r <= 4'h1;
				2'h2: gainMultiplier_r <= 4'h2;
				2'h3: gainMultiplier_r <= 4'h3;
			endcase
		end
	end

	// Threshold comparison

	assign lowThresh = {lowThreshHi_r, lowThreshLo_r};
	assign highThresh = {highThreshHi_r, highThreshLo_r};
	// Strict compares: a result equal to a threshold is in range
	assign outOfRange = (clearResult < lowThresh) ||
		(clearResult > highThresh);

	// Shared terms keep the status bit and the pin in step
	assign resultTaken = measureEnable && resultStrobe;
	assign intSet = intFire && interruptEnableBit;
	// Clear loses to a same-cycle set so no event is missed
	assign clearTaken = intClearCmd && !intSet;

	// Persistence filter

	always_comb begin
		oorCount_nxt = oorCount_r;
		if (!outOfRange) begin
			oorCount_nxt = 6'h00;
		end else if (oorCount_r != cwt_pkg::OOR_COUNT_MAX) begin
			// Saturate rather than wrap so long runs keep firing
			oorCount_nxt = oorCount_r + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oorCount_r <= 6'h00;
		end else if (!measureEnable) begin
			oorCount_r <= 6'h00;
		end else if (resultStrobe) begin
			oorCount_r <= oorCount_nxt;
		end
	end

	always_comb begin
		intFire = 1'b0;
		if (resultTaken) begin
			if (interruptFilterCount_r == cwt_pkg::FILTER_EVERY) begin
				intFire = 1'b1;
			end else begin
				// Count includes this result, so code one fires at once
				intFire = outOfRange &&
					(oorCount_nxt >= filterNeed(interruptFilterCount_r));
			end
		end
	end

	// Interrupt flag: a new event wins over a same-cycle clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			thresholdIntFlag_r <= 1'b0;
		end else if (intSet) begin
			thresholdIntFlag_r <= 1'b1;
		end else if (clearTaken) begin
			thresholdIntFlag_r <= 1'b0;
		end
	end

	// Pin mirrors the flag, held until the clear command
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			intPinOe_r <= 1'b0;
		end else if (intSet) begin
			intPinOe_r <= 1'b1;
		end else if (clearTaken) begin
			intPinOe_r <= 1'b0;
		end
	end

	// Valid flag sets per integration, drops when measuring stops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resultValidFlag_r <= 1'b0;
		end else if (resultTaken) begin
			resultValidFlag_r <= 1'b1;
		end else if (!measureEnable) begin
			resultValidFlag_r <= 1'b0;
		end
	end

	// Status byte; no write path exists for it
	always_comb begin
		statusByte = 8'h00;
		statusByte[cwt_pkg::STATUS_INT_BIT] = thresholdIntFlag_r;
		statusByte[cwt_pkg::STATUS_VALID_BIT] = resultValidFlag_r;
	end

	// Read path, unmapped addresses return zero
	// Reserved bits read as zero whatever the host wrote there
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_r <= 8'h00;
		end else if (regRdEn) begin
			unique case (regAddr)
				cwt_pkg::ADDR_WAIT_INTERVAL: regRdData_r <= waitIntervalSetting_r;
				cwt_pkg::ADDR_LOW_THRESH_LO: regRdData_r <= lowThreshLo_r;
				cwt_pkg::ADDR_LOW_THRESH_HI: regRdData_r <= lowThreshHi_r;
				cwt_pkg::ADDR_HIGH_THRESH_LO: regRdData_r <= highThreshLo_r;
				cwt_pkg::ADDR_HIGH_THRESH_HI: regRdData_r <= highThreshHi_r;
				cwt_pkg::ADDR_INTERRUPT_FILTER:
					regRdData_r <= {4'h0, interruptFilterCount_r};
				cwt_pkg::ADDR_WAIT_CONFIG: begin
					regRdData_r <= 8'h00;
					regRdData_r[cwt_pkg::LONG_WAIT_BIT] <= longWaitSelect_r;
				end
				cwt_pkg::ADDR_GAIN_CONTROL:
					regRdData_r <= {6'h00, analogGainSelect_r};
				cwt_pkg::ADDR_PART_IDENTITY: regRdData_r <= PART_IDENTITY;
				cwt_pkg::ADDR_SENSOR_STATUS: regRdData_r <= statusByte;
				default: regRdData_r <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdValid_r <= 1'b0;
		end else begin
			regRdValid_r <= regRdEn;
		end
	end

	// Wait interval timer

	cwt_wait_timer #(
		.STEP_CYCLES(WAIT_STEP_CYCLES),
		.LONG_FACTOR(cwt_pkg::LONG_WAIT_FACTOR)
	) u_wait_timer (
		.clk(clk),
		.rst_b(rst_b),
		.start(waitStart),
		.waitEnable(waitEnable),
		.waitSetting(waitIntervalSetting_r),
		.longWait(longWaitSelect_r),
		.busy(timerBusy),
		.done(timerDone)
	);

	// Registered copies keep top outputs flop-driven, one cycle late
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitBusy_r <= 1'b0;
			waitDone_r <= 1'b0;
		end else begin
			waitBusy_r <= timerBusy;
			waitDone_r <= timerDone;
		end
	end

	assign regRdData = regRdData_r;
	assign regRdValid = regRdValid_r;
	assign waitBusy = waitBusy_r;
	assign waitDone = waitDone_r;
	assign analogGainSelect = analogGainSelect_r;
	assign gainMultiplier = gainMultiplier_r;
	// Open drain: level is always low, only the enable moves
	assign intPinOut = 1'b0;
	assign intPinOe = intPinOe_r;

endmodule
`default_nettype wire

// ### src/cwt_wait_timer.sv
// Wait interval timer between color measurements.
// Assumes start is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cwt_wait_timer #(
	parameter int STEP_CYCLES = cwt_pkg::WAIT_STEP_CYCLES,
	parameter int LONG_FACTOR = cwt_pkg::LONG_WAIT_FACTOR
) (
	input wire logic clk, // Core clock
	input wire logic rst_b, // Async reset, active low
	input wire logic start, // Begin a wait interval
	input wire logic waitEnable, // Wait feature on
	input wire logic [7:0] waitSetting, // Two's complement step count
	input wire logic longWait, // Twelvefold stretch
	output logic busy, // Wait in progress
	output logic done // One-cycle end of wait
);
	cwt_pkg::cwt_wait_state_t state_r;
	logic [31:0] preCnt_r;
	logic [3:0] longCnt_r;
	logic [8:0] stepsLeft_r;
	logic longSel_r;
	logic stepTick;
	logic unitTick;

	// Prescaler gives one pulse per base step
	assign stepTick = (state_r == cwt_pkg::WT_RUN) &&
		(preCnt_r == 32'(STEP_CYCLES - 1));
	assign unitTick = stepTick &&
		(!longSel_r || longCnt_r == 4'(LONG_FACTOR - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= cwt_pkg::WT_IDLE;
		end else begin
			unique case (state_r)
				cwt_pkg::WT_IDLE: begin
					if (start) begin
						// Disabled wait ends at once, sequencer never stalls
						state_r <= waitEnable ? cwt_pkg::WT_RUN :
							cwt_pkg::WT_DONE;
					end
				end
				cwt_pkg::WT_RUN: begin
					if (!waitEnable || (unitTick && stepsLeft_r == 9'h001)) begin
						state_r <= cwt_pkg::WT_DONE;
					end
				end
				cwt_pkg::WT_DONE: state_r <= cwt_pkg::WT_IDLE;
				default: state_r <= cwt_pkg::WT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_r <= 32'h0;
			longCnt_r <= 4'h0;
		end else if (state_r != cwt_pkg::WT_RUN || stepTick) begin
			preCnt_r <= 32'h0;
			if (state_r != cwt_pkg::WT_RUN || unitTick) begin
				longCnt_r <= 4'h0;
			end else begin
				longCnt_r <= longCnt_r + 4'h1;
			end
		end else begin
			preCnt_r <= preCnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stepsLeft_r <= 9'h0;
			longSel_r <= 1'b0;
		end else if (state_r == cwt_pkg::WT_IDLE && start) begin
			// 0xff gives one step, 0x00 gives 256
			stepsLeft_r <= cwt_pkg::WAIT_STEPS_FULL - {1'b0, waitSetting};
			longSel_r <= longWait;
		end else if (unitTick) begin
			stepsLeft_r <= stepsLeft_r - 9'h001;
		end
	end

	assign busy = (state_r == cwt_pkg::WT_RUN);
	assign done = (state_r == cwt_pkg::WT_DONE);

endmodule
`default_nettype wire

// ### verification/cwt_host_model.sv
// Host processor model: byte register accesses and interrupt clear.
// Assumes the design samples strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cwt_host_model (
	input wire logic clk, // Core clock
	output logic [4:0] regAddr, // Register address
	output logic [7:0] regWrData, // Write byte
	output logic regWrEn, // Write strobe
	output logic regRdEn, // Read strobe
	output logic intClearCmd, // Clear command pulse
	input wire logic [7:0] regRdData, // Read byte
	input wire logic regRdValid // Read valid pulse
);
	initial begin
		regAddr = 5'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		intClearCmd = 1'b0;
	end
	// Released lines show the inverse so stale values never match
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clk);
		#1;
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clk);
		#1;
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
		v = regRdValid;
	endtask
	task automatic clr();
		@(posedge clk);
		#1;
		intClearCmd = 1'b1;
		@(posedge clk);
		#1;
		intClearCmd = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verification/cwt_threshold_status_bench.sv
// Self-checking bench for the wait, threshold and status block.
// Assumes the host model drives the register side; the bench the rest.
`timescale 1ns/1ps
`default_nettype none
module cwt_threshold_status_bench;
	localparam int STEP = 4;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
	logic clk = 1'b0;
	logic rst_b, intClearCmd, regWrEn, regRdEn, regRdValid;
	logic interruptEnableBit, waitEnable, measureEnable, resultStrobe;
	logic waitStart, waitBusy, waitDone, intPinOut, intPinOe;
	logic [4:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [15:0] clearResult;
	logic [1:0] analogGainSelect;
	logic [3:0] gainMultiplier;
	int nFail = 0;
	int checksDone = 0;
	always #2 clk = ~clk;
	cwt_threshold_status #(.WAIT_STEP_CYCLES(STEP), .PART_IDENTITY(ID),
		.RESULT_W(16)) dut (.clk, .rst_b, .regAddr, .regWrData, .regWrEn,
		.regRdEn, .regRdData, .regRdValid, .intClearCmd,
		.interruptEnableBit, .waitEnable, .measureEnable, .resultStrobe,
		.clearResult, .waitStart, .waitBusy, .waitDone, .analogGainSelect,
		.gainMultiplier, .intPinOut, .intPinOe);
	cwt_host_model host (.clk, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.intClearCmd, .regRdData, .regRdValid);
	task automatic chk(input string w, input logic [15:0] s,
		input logic [15:0] e);
		checksDone++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", w, e, s);
			nFail++;
		end
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk("read valid", v, 1);
		chk("read data", d, e);
	endtask
	task automatic res(input logic [15:0] v);
		@(posedge clk);
		#1;
		clearResult = v;
		resultStrobe = 1'b1;
		@(posedge clk);
		#1;
		resultStrobe = 1'b0;
		clearResult = ~v;
	endtask
	task automatic tRegs();
		logic [4:0] a[8] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c,
			5'h0d, 5'h0f};
		logic [7:0] e[8] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
			8'h00, 8'h00};
		foreach (a[i]) rdChk(a[i], e[i]);
		rdChk(5'h12, ID);
		rdChk(5'h13, 8'h00);
		host.wr(5'h12, 8'h00);
		rdChk(5'h12, ID);
		host.wr(5'h13, 8'hff);
		rdChk(5'h13, 8'h00);
		host.wr(5'h0d, 8'hff);
		rdChk(5'h0d, 8'h02);
		rdChk(5'h1f, 8'h00);
		for (int g = 0; g < 4; g++) begin
			host.wr(5'h0f, 8'(g));
			repeat (2) @(posedge clk);
			#1;
			chk("gain select", analogGainSelect, 16'(g));
			chk("gain code", gainMultiplier, 16'(g));
		end
	endtask
	task automatic tThresh();
		host.wr(5'h04, 8'h00);
		host.wr(5'h05, 8'h01);
		host.wr(5'h06, 8'h00);
		host.wr(5'h07, 8'h02);
		host.wr(5'h0c, 8'h01);
		res(16'h0100);
		res(16'h0150);
		res(16'h0200);
		chk("in range", intPinOe, 0);
		res(16'h0201);
		chk("above high", intPinOe, 1);
		chk("pin level", intPinOut, 0);
		rdChk(5'h13, 8'h11);
		res(16'h0150);
		chk("held", intPinOe, 1);
		host.clr();
		chk("cleared", intPinOe, 0);
		rdChk(5'h13, 8'h01);
		res(16'h00ff);
		chk("below low", intPinOe, 1);
		host.clr();
	endtask
	task automatic tPersist();
		int need;
		host.wr(5'h0c, 8'h00);
		res(16'h0150);
		chk("every result", intPinOe, 1);
		host.clr();
		for (int c = 1; c < 16; c++) begin
			need = (c < 4) ? c : 5 * (c - 3);
			host.wr(5'h0c, 8'(c));
			res(16'h0150);
			if (need > 1) begin
				res(16'h0300);
				res(16'h0150);
			end
			repeat (need - 1) res(16'h0300);
			chk("early", intPinOe, 0);
			res(16'h0300);
			chk("persist", intPinOe, 1);
			host.clr();
		end
	endtask
	task automatic tEnable();
		host.wr(5'h0c, 8'h01);
		interruptEnableBit = 1'b0;
		res(16'h0300);
		chk("disabled", intPinOe, 0);
		interruptEnableBit = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("not kept", intPinOe, 0);
		measureEnable = 1'b0;
		res(16'h0300);
		chk("idle measure", intPinOe, 0);
		rdChk(5'h13, 8'h00);
		measureEnable = 1'b1;
	endtask
	task automatic runWait(input logic [7:0] s, input logic [7:0] cfg,
		input logic en, input int exp);
		int n;
		logic b;
		host.wr(5'h03, s);
		host.wr(5'h0d, cfg);
		waitEnable = en;
		@(posedge clk);
		#1;
		waitStart = 1'b1;
		@(posedge clk);
		#1;
		waitStart = 1'b0;
		n = 0;
		while (waitDone !== 1'b1 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
			if (n == 1) b = waitBusy;
		end
		chk("wait cycles", 16'(n), 16'(exp));
		chk("wait busy", b, en);
		chk("wait idle", waitBusy, 0);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		interruptEnableBit = 1'b1;
		waitEnable = 1'b1;
		measureEnable = 1'b1;
		resultStrobe = 1'b0;
		clearResult = 16'h0000;
		waitStart = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_b = 1'b1;
		tRegs();
		tThresh();
		tPersist();
		tEnable();
		runWait(8'hff, 8'h00, 1'b1, STEP + 1);
		runWait(8'h00, 8'h00, 1'b1, 256 * STEP + 1);
		runWait(8'hfe, 8'h02, 1'b1, 2 * STEP * 12 + 1);
		runWait(8'hff, 8'h00, 1'b0, 1);
		results();
	end
	initial begin
		#200000;
		nFail++;
		results();
	end
endmodule
`default_nettype wire

// ### verification/cwt_threshold_status_chk.sv
// Port checker for the wait, threshold and status block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cwt_threshold_status_chk #(
	parameter logic [7:0] PART_IDENTITY = 8'h00
) (
	input wire logic clk, // Core clock
	input wire logic rst_b, // Reset, active low
	input wire logic [4:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Write byte
	input wire logic regWrEn, // Write strobe
	input wire logic regRdEn, // Read strobe
	input wire logic [7:0] regRdData, // Read byte
	input wire logic intClearCmd, // Clear command pulse
	input wire logic interruptEnableBit, // Interrupt enable
	input wire logic measureEnable, // Measurement enable
	input wire logic resultStrobe, // Result pulse
	input wire logic waitDone, // Wait end pulse
	input wire logic [1:0] analogGainSelect, // Gain code
	input wire logic intPinOe // Interrupt asserted
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	idRead_a: assert property (
		regRdEn && regAddr == cwt_pkg::ADDR_PART_IDENTITY
		|=> regRdData == PART_IDENTITY) else $error("identity read wrong");
	statusRead_a: assert property (
		regRdEn && regAddr == cwt_pkg::ADDR_SENSOR_STATUS
		|=> regRdData[4] == $past(intPinOe) && regRdData[3:1] == 3'h0)
		else $error("status flag differs from pin");
	gainWrite_a: assert property (
		regWrEn && regAddr == cwt_pkg::ADDR_GAIN_CONTROL
		|=> analogGainSelect == $past(regWrData[1:0]))
		else $error("gain select not written");
	intCause_a: assert property ($rose(intPinOe)
		|-> $past(resultStrobe && measureEnable))
		else $error("interrupt without a result");
	intNoEnable_a: assert property (
		!intPinOe && !interruptEnableBit |=> !intPinOe)
		else $error("interrupt while disabled");
	intClear_a: assert property (
		intClearCmd && !resultStrobe |=> !intPinOe)
		else $error("clear left interrupt set");
	intHold_a: assert property (
		intPinOe && !intClearCmd |=> intPinOe)
		else $error("interrupt dropped without clear");
	waitPulse_a: assert property (waitDone |=> !waitDone)
		else $error("wait done longer than a cycle");
	cover property (intPinOe && intClearCmd);
	cover property (waitDone);
	cover property (regRdEn && regAddr == cwt_pkg::ADDR_SENSOR_STATUS);
endmodule
bind cwt_threshold_status cwt_threshold_status_chk #(
	.PART_IDENTITY(PART_IDENTITY)
) chk (.clk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn,
	.regRdData, .intClearCmd, .interruptEnableBit, .measureEnable,
	.resultStrobe, .waitDone, .analogGainSelect, .intPinOe);
`default_nettype wire
